/* inc/smp_pkg.sv */
// Constants and types shared by the serial programming port files.
// Assumes it is compiled before every file that names it.
package smp_pkg;

   // Widths of addresses, data, timer and shift counters.
   localparam int FL_AW   = 12;  // Flash word address width.
   localparam int PG_W    = 5;   // Word-in-page address width.
   localparam int PGN_W   = 7;   // Page number width.
   localparam int EE_AW   = 9;   // EEPROM byte address width.
   localparam int TMR_W   = 20;  // Write timer width.
   localparam int CNT_W   = 5;   // Bit counter width.
   localparam int INSTR_W = 32;  // One whole instruction.
   localparam int HDR_W   = 24;  // First three bytes of it.

   // Bit counter marks: header complete and last bit of a frame.
   localparam logic [4:0] CNT_HDR  = 5'h18;
   localparam logic [4:0] CNT_LAST = 5'h1F;

   // Instruction codes, first and second byte.
   localparam logic [7:0] OP_PEN1  = 8'hAC;  // Enable and special group.
   localparam logic [7:0] OP_PEN2  = 8'h53;  // Enable second byte.
   localparam logic [3:0] OP_RDFL  = 4'h2;   // Flash read, upper nibble.
   localparam logic [3:0] OP_LDPG  = 4'h4;   // Page load, upper nibble.
   localparam logic [2:0] OP_LOW0  = 3'h0;   // Low bits of read and load.
   localparam logic [7:0] OP_WRPG  = 8'h4C;
   localparam logic [7:0] OP_RDEE  = 8'hA0;
   localparam logic [7:0] OP_WREE  = 8'hC0;
   localparam logic [7:0] OP_RDLK  = 8'h58;
   localparam logic [7:0] OP_RDFU  = 8'h50;
   localparam logic [7:0] OP_RDSIG = 8'h30;
   localparam logic [7:0] OP_RDCAL = 8'h38;
   localparam logic [2:0] SUB_ERASE = 3'h4;
   localparam logic [2:0] SUB_WRLK  = 3'h7;
   localparam logic [7:0] SUB_WRFU  = 8'hA0;
   localparam logic [7:0] SUB_WRFH  = 8'hA8;
   localparam logic [7:0] SUB_RDFH  = 8'h08;
   localparam logic [7:0] SUB_ZERO  = 8'h00;
   localparam int         H_BIT     = 3;     // High or low byte select.

   // Erased and reset values.
   localparam logic [7:0]  ERASED_BYTE = 8'hFF;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;
   localparam logic [7:0]  RD_NONE     = 8'h00;
   localparam logic [7:0]  LOCK_RST    = 8'hFF;
   localparam logic [7:0]  LOCK_KEEP   = 8'hC0;
   localparam logic [7:0]  FUSE_LO_RST = 8'hFF;
   localparam logic [7:0]  FUSE_HI_RST = 8'hFF;

   // Self-timed write delays in milliseconds and the clock rate.
   localparam real MCLK_MHZ        = 100.0;
   localparam real FLASH_WAIT_MS   = 4.5;
   localparam real EEPROM_WAIT_MS  = 9.0;
   localparam real ERASE_WAIT_MS   = 9.0;
   localparam int  FLASH_WAIT_CYC  = int'($ceil(FLASH_WAIT_MS * 1000.0 * MCLK_MHZ));
   localparam int  EEPROM_WAIT_CYC = int'($ceil(EEPROM_WAIT_MS * 1000.0 * MCLK_MHZ));
   localparam int  ERASE_WAIT_CYC  = int'($ceil(ERASE_WAIT_MS * 1000.0 * MCLK_MHZ));

   // Sequencer states, one-hot.
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,  // Ready for any instruction.
      ST_FLW  = 7'h02,  // Page write delay running.
      ST_FLC  = 7'h04,  // Page buffer copied into the array.
      ST_EEW  = 7'h08,  // EEPROM byte delay running.
      ST_ERW  = 7'h10,  // Chip erase delay running.
      ST_ERS  = 7'h20,  // Both arrays swept to erased.
      ST_NVW  = 7'h40   // Lock or fuse write delay running.
   } smp_st_e;

   // Words handed from the link domain to the core.
   typedef struct packed {
      logic [HDR_W-1:0]   hdr;      // First three bytes.
      logic [INSTR_W-1:0] cmd;      // Whole instruction.
      logic               hdr_tgl;  // Flips when hdr is new.
      logic               cmd_tgl;  // Flips when cmd is new.
   } smp_lnk_s;

   // Receive state on the rising edge of the link clock.
   typedef struct packed {
      logic [CNT_W-1:0]   cnt;
      logic [INSTR_W-1:0] sh;
      smp_lnk_s           lnk;
   } smp_rx_s;

   // Transmit state on the falling edge of the link clock.
   typedef struct packed {
      logic [7:0] sh;
   } smp_tx_s;

   // Core state in the system clock domain.
   typedef struct packed {
      smp_st_e          st;
      logic [TMR_W-1:0] tmr;
      logic [FL_AW-1:0] idx;
      logic [PGN_W-1:0] pg;
      logic [EE_AW-1:0] ea;
      logic [7:0]       ed;
      logic             prog_en;
      logic [1:0]       seen;
      logic [7:0]       rd;
      logic [7:0]       lock;
      logic [7:0]       fuse_lo;
      logic [7:0]       fuse_hi;
   } smp_core_s;

endpackage

/* core/smp_sync.sv */
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit changes slowly against the destination clock.
`timescale 1ns/1ns
`default_nettype none
module smp_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   // Stage 0 is read only by stage 1.
   logic [1:0][W-1:0] st_ff;
   logic [1:0][W-1:0] nxt_st;

   // Next value shifts the input one stage along.
   always_comb begin
      nxt_st = {st_ff[0], d};
   end

   // Both stages clear to zero under reset.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign q = st_ff[1];
endmodule // smp_sync
`default_nettype wire

/* core/smp_link.sv */
// Serial shifter clocked by the programmer's link clock.
// Assumes the link clock idles low and is held in reset outside a session.
`timescale 1ns/1ns
`default_nettype none
module smp_link (
   input  wire logic            sck,
   input  wire logic            link_rst_n,
   input  wire logic            mosi,
   input  wire logic [7:0]      rd_byte,
   output logic                 miso,
   output smp_pkg::smp_lnk_s    lnk
);
   smp_pkg::smp_rx_s rx_ff;   // Receive state.
   smp_pkg::smp_rx_s nxt_rx;  // Its next value.
   smp_pkg::smp_tx_s tx_ff;   // Transmit state.
   smp_pkg::smp_tx_s nxt_tx;  // Its next value.

   // Shift one bit in, msb first, and publish header and frame.
   always_comb begin
      nxt_rx     = rx_ff;
      nxt_rx.cnt = rx_ff.cnt + 5'h01;
      nxt_rx.sh  = {rx_ff.sh[30:0], mosi};
      if (nxt_rx.cnt == smp_pkg::CNT_HDR) begin
         nxt_rx.lnk.hdr     = nxt_rx.sh[23:0];
         nxt_rx.lnk.hdr_tgl = ~rx_ff.lnk.hdr_tgl;
      end
      if (rx_ff.cnt == smp_pkg::CNT_LAST) begin
         nxt_rx.lnk.cmd     = nxt_rx.sh;
         nxt_rx.lnk.cmd_tgl = ~rx_ff.lnk.cmd_tgl;
      end
   end

   // Input data is taken on the rising edge.
   always_ff @(posedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rx_ff <= '0;
      end else begin
         rx_ff <= nxt_rx;
      end
   end

   // At a byte boundary load the echo, or read data for the last byte.
   always_comb begin
      nxt_tx = tx_ff;
      if (rx_ff.cnt[2:0] == 3'h0) begin
         if (rx_ff.cnt == smp_pkg::CNT_HDR) begin
            nxt_tx.sh = rd_byte;
         end else begin
            nxt_tx.sh = rx_ff.sh[7:0];
         end
      end else begin
         nxt_tx.sh = {tx_ff.sh[6:0], 1'b0};
      end
   end

   // Output data moves on the falling edge.
   always_ff @(negedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         tx_ff <= '0;
      end else begin
         tx_ff <= nxt_tx;
      end
   end

   assign miso = tx_ff.sh[7];
   assign lnk  = rx_ff.lnk;
endmodule // smp_link
`default_nettype wire

/* core/smp_core.sv */
// Serial programming port: link shifter, crossing and memory sequencer.
// Assumes the programmer holds the reset pin low for a whole session and
// keeps each link clock phase at least six system clocks long.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Program only while reset pin held low.
// - Reject writes until programming enable completes.
// - EEPROM write erases its byte itself.
// - Chip erase sets both arrays to FF.
// - Sample input data on rising edge.
// - Shift output data on falling edge.
// - Echo second enable byte during third.
// - Page buffer loaded per byte, low first.
// - Page write uses seven page bits.
// - EEPROM written one byte per instruction.
// - Read returns addressed location on output.
// - Releasing reset leaves programming mode.
// - Busy page reads FF until done.
// - Enable is AC 53 xx xx, reset low.
// - Busy EEPROM byte reads FF until done.
module smp_core #(
   parameter int         FLASH_WAIT_CYC  = smp_pkg::FLASH_WAIT_CYC,
   parameter int         EEPROM_WAIT_CYC = smp_pkg::EEPROM_WAIT_CYC,
   parameter int         ERASE_WAIT_CYC  = smp_pkg::ERASE_WAIT_CYC,
   parameter logic [7:0] SIG0            = 8'h5A,  // Arbitrary value.
   parameter logic [7:0] SIG1            = 8'h01,  // Arbitrary value.
   parameter logic [7:0] SIG2            = 8'h02,  // Arbitrary value.
   parameter logic [7:0] CAL             = 8'h80   // Arbitrary value.
) (
   input  wire logic mclk,
   input  wire logic resetn,
   input  wire logic sck,
   input  wire logic mosi,
   input  wire logic rst_pin_n,
   output logic      miso,
   output logic      prog_mode,
   output logic      nvm_busy,
   output logic      cpu_run
);
   // Short names for widths.
   localparam int TW  = smp_pkg::TMR_W;
   localparam int AW  = smp_pkg::FL_AW;
   localparam int EW  = smp_pkg::EE_AW;
   localparam int PW  = smp_pkg::PG_W;
   localparam int NPG = 1 << PW;

   // Last timer value of each delay; none is shorter than one cycle.
   localparam logic [TW-1:0] FL_END = TW'(FLASH_WAIT_CYC - 1);
   localparam logic [TW-1:0] EE_END = TW'(EEPROM_WAIT_CYC - 1);
   localparam logic [TW-1:0] ER_END = TW'(ERASE_WAIT_CYC - 1);

   // Last index of a page copy and of an array sweep.
   localparam logic [PW-1:0] PG_LAST  = '1;
   localparam logic [AW-1:0] IDX_LAST = '1;

   // Core state and its next value.
   smp_pkg::smp_core_s cur_ff;
   smp_pkg::smp_core_s nxt;

   // Memories: program array, data array and the page buffer.
   logic [15:0] fl_mem [0:(1<<AW)-1];
   logic [7:0]  ee_mem [0:(1<<EW)-1];
   logic [15:0] pb_mem [0:NPG-1];

   // Write ports of the three memories, driven by the sequencer.
   logic          fl_we;
   logic [AW-1:0] fl_wa;
   logic [15:0]   fl_wd;
   logic          ee_we;
   logic [EW-1:0] ee_wa;
   logic [7:0]    ee_wd;
   logic          pb_we;
   logic [PW-1:0] pb_wa;
   logic [15:0]   pb_wd;

   // Words and toggles coming from the link domain.
   smp_pkg::smp_lnk_s lnk;
   logic [2:0]        syn;      // {reset pin, cmd toggle, hdr toggle}.
   logic              rel;      // Reset pin seen released.
   logic              hdr_ev;   // New header arrived.
   logic              cmd_ev;   // New instruction arrived.
   logic              link_rst_n;

   // Header and instruction bytes, numbered in the order sent.
   logic [7:0] h1;
   logic [7:0] h2;
   logic [7:0] h3;
   logic [7:0] c1;
   logic [7:0] c2;
   logic [7:0] c3;
   logic [7:0] c4;

   // Decoded read addresses and the words they select.
   logic [AW-1:0] rfa;
   logic [EW-1:0] rea;
   logic [15:0]   rfw;
   logic [7:0]    ree;
   logic [3:0][7:0] sig_tab;

   // Link logic is held idle whenever the reset pin is high.
   assign link_rst_n = resetn & ~rst_pin_n;

   // Shifter running on the programmer's clock.
   smp_link u_link (
      .sck        (sck),
      .link_rst_n (link_rst_n),
      .mosi       (mosi),
      .rd_byte    (cur_ff.rd),
      .miso       (miso),
      .lnk        (lnk)
   );

   // Reset pin level and both toggles cross on two flip-flops each.
   smp_sync #(
      .W (3)
   ) u_sync (
      .clk   (mclk),
      .rst_n (resetn),
      .d     ({rst_pin_n, lnk.cmd_tgl, lnk.hdr_tgl}),
      .q     (syn)
   );

   // A toggle that differs from the last seen copy is a new word.
   // The word itself stays still for a whole byte after its toggle.
   assign rel    = syn[2];
   assign hdr_ev = syn[0] ^ cur_ff.seen[0];
   assign cmd_ev = syn[1] ^ cur_ff.seen[1];

   // Byte fields of the header and of the whole instruction.
   assign h1 = lnk.hdr[23:16];
   assign h2 = lnk.hdr[15:8];
   assign h3 = lnk.hdr[7:0];
   assign c1 = lnk.cmd[31:24];
   assign c2 = lnk.cmd[23:16];
   assign c3 = lnk.cmd[15:8];
   assign c4 = lnk.cmd[7:0];

   // Read addresses come from the second and third bytes.
   assign rfa = {h2[3:0], h3};
   assign rea = {h2[0], h3};
   assign rfw = fl_mem[rfa];
   assign ree = ee_mem[rea];
   assign sig_tab = {smp_pkg::RD_NONE, SIG2, SIG1, SIG0};

   // Sequencer: read answers, instruction decode and timed writes.
   always_comb begin
      nxt      = cur_ff;
      nxt.seen = syn[1:0];
      nxt.tmr  = cur_ff.tmr + 20'h00001;
      fl_we    = 1'b0;
      fl_wa    = '0;
      fl_wd    = smp_pkg::ERASED_WORD;
      ee_we    = 1'b0;
      ee_wa    = '0;
      ee_wd    = smp_pkg::ERASED_BYTE;
      pb_we    = 1'b0;
      pb_wa    = c3[PW-1:0];
      pb_wd    = pb_mem[c3[PW-1:0]];

      // Programming mode ends as soon as the reset pin is released.
      if (rel) begin
         nxt.prog_en = 1'b0;
      end else if (cmd_ev && c1 == smp_pkg::OP_PEN1
                   && c2 == smp_pkg::OP_PEN2) begin
         // Enable is honoured only while the pin is still low.
         nxt.prog_en = 1'b1;
      end

      // Prepare the fourth byte as soon as the header is complete.
      if (hdr_ev) begin
         nxt.rd = smp_pkg::RD_NONE;
         if (cur_ff.prog_en) begin
            if (h1[7:4] == smp_pkg::OP_RDFL && h1[2:0] == smp_pkg::OP_LOW0) begin
               // A page still being written reads as erased.
               if ((cur_ff.st == smp_pkg::ST_FLW || cur_ff.st == smp_pkg::ST_FLC)
                   && rfa[AW-1:PW] == cur_ff.pg) begin
                  nxt.rd = smp_pkg::ERASED_BYTE;
               end else if (h1[smp_pkg::H_BIT]) begin
                  nxt.rd = rfw[15:8];
               end else begin
                  nxt.rd = rfw[7:0];
               end
            end else if (h1 == smp_pkg::OP_RDEE) begin
               // The byte being written reads as erased until done.
               if (cur_ff.st == smp_pkg::ST_EEW && rea == cur_ff.ea) begin
                  nxt.rd = smp_pkg::ERASED_BYTE;
               end else begin
                  nxt.rd = ree;
               end
            end else if (h1 == smp_pkg::OP_RDLK && h2 == smp_pkg::SUB_ZERO) begin
               nxt.rd = cur_ff.lock;
            end else if (h1 == smp_pkg::OP_RDLK && h2 == smp_pkg::SUB_RDFH) begin
               nxt.rd = cur_ff.fuse_hi;
            end else if (h1 == smp_pkg::OP_RDFU) begin
               nxt.rd = cur_ff.fuse_lo;
            end else if (h1 == smp_pkg::OP_RDSIG) begin
               nxt.rd = sig_tab[h3[1:0]];
            end else if (h1 == smp_pkg::OP_RDCAL) begin
               nxt.rd = CAL;
            end
         end
      end

      unique case (cur_ff.st)
         smp_pkg::ST_IDLE: begin
            // Writes are taken only after enable, and only when idle.
            if (cmd_ev && cur_ff.prog_en) begin
               if (c1 == smp_pkg::OP_PEN1) begin
                  if (c2[7:5] == smp_pkg::SUB_ERASE) begin
                     nxt.st  = smp_pkg::ST_ERW;
                     nxt.tmr = '0;
                  end else if (c2[7:5] == smp_pkg::SUB_WRLK) begin
                     // Lock bits can only be programmed towards zero.
                     nxt.lock = cur_ff.lock & (c4 | smp_pkg::LOCK_KEEP);
                     nxt.st   = smp_pkg::ST_NVW;
                     nxt.tmr  = '0;
                  end else if (c2 == smp_pkg::SUB_WRFU) begin
                     nxt.fuse_lo = c4;
                     nxt.st      = smp_pkg::ST_NVW;
                     nxt.tmr     = '0;
                  end else if (c2 == smp_pkg::SUB_WRFH) begin
                     nxt.fuse_hi = c4;
                     nxt.st      = smp_pkg::ST_NVW;
                     nxt.tmr     = '0;
                  end
               end else if (c1[7:4] == smp_pkg::OP_LDPG
                            && c1[2:0] == smp_pkg::OP_LOW0) begin
                  // One byte into the buffer word named by five bits.
                  pb_we = 1'b1;
                  if (c1[smp_pkg::H_BIT]) begin
                     pb_wd = {c4, pb_mem[c3[PW-1:0]][7:0]};
                  end else begin
                     pb_wd = {pb_mem[c3[PW-1:0]][15:8], c4};
                  end
               end else if (c1 == smp_pkg::OP_WRPG) begin
                  // Page number is the seven upper word address bits.
                  nxt.pg  = {c2[3:0], c3[7:5]};
                  nxt.st  = smp_pkg::ST_FLW;
                  nxt.tmr = '0;
               end else if (c1 == smp_pkg::OP_WREE) begin
                  // Address and data arrive in the same instruction.
                  nxt.ea  = {c2[0], c3};
                  nxt.ed  = c4;
                  nxt.st  = smp_pkg::ST_EEW;
                  nxt.tmr = '0;
               end
            end
         end
         smp_pkg::ST_FLW: begin
            // Page delay; the programmer only polls meanwhile.
            if (cur_ff.tmr == FL_END) begin
               nxt.st  = smp_pkg::ST_FLC;
               nxt.idx = '0;
            end
         end
         smp_pkg::ST_FLC: begin
            // Copy one buffer word per cycle into the chosen page.
            fl_we   = 1'b1;
            fl_wa   = {cur_ff.pg, cur_ff.idx[PW-1:0]};
            fl_wd   = pb_mem[cur_ff.idx[PW-1:0]];
            nxt.idx = cur_ff.idx + 12'h001;
            if (cur_ff.idx[PW-1:0] == PG_LAST) begin
               nxt.st = smp_pkg::ST_IDLE;
            end
         end
         smp_pkg::ST_EEW: begin
            // The new byte replaces the old one outright, so the
            // erase of the location is part of this one write.
            if (cur_ff.tmr == EE_END) begin
               ee_we  = 1'b1;
               ee_wa  = cur_ff.ea;
               ee_wd  = cur_ff.ed;
               nxt.st = smp_pkg::ST_IDLE;
            end
         end
         smp_pkg::ST_ERW: begin
            // Erase delay, then the sweep of both arrays.
            if (cur_ff.tmr == ER_END) begin
               nxt.st   = smp_pkg::ST_ERS;
               nxt.idx  = '0;
               nxt.lock = smp_pkg::LOCK_RST;
            end
         end
         smp_pkg::ST_ERS: begin
            // One program word and one data byte erased per cycle.
            fl_we   = 1'b1;
            fl_wa   = cur_ff.idx;
            ee_we   = 1'b1;
            ee_wa   = cur_ff.idx[EW-1:0];
            nxt.idx = cur_ff.idx + 12'h001;
            if (cur_ff.idx == IDX_LAST) begin
               nxt.st = smp_pkg::ST_IDLE;
            end
         end
         smp_pkg::ST_NVW: begin
            // Lock and fuse writes use the page delay.
            if (cur_ff.tmr == FL_END) begin
               nxt.st = smp_pkg::ST_IDLE;
            end
         end
      endcase
   end

   // Core state register.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cur_ff.st      <= smp_pkg::ST_IDLE;
         cur_ff.tmr     <= '0;
         cur_ff.idx     <= '0;
         cur_ff.pg      <= '0;
         cur_ff.ea      <= '0;
         cur_ff.ed      <= '0;
         cur_ff.prog_en <= 1'b0;
         cur_ff.seen    <= '0;
         cur_ff.rd      <= smp_pkg::RD_NONE;
         cur_ff.lock    <= smp_pkg::LOCK_RST;
         cur_ff.fuse_lo <= smp_pkg::FUSE_LO_RST;
         cur_ff.fuse_hi <= smp_pkg::FUSE_HI_RST;
      end else begin
         cur_ff <= nxt;
      end
   end

   // Program array write port; contents are unknown until written.
   always_ff @(posedge mclk) begin
      if (fl_we) begin
         fl_mem[fl_wa] <= fl_wd;
      end
   end

   // Data array write port.
   always_ff @(posedge mclk) begin
      if (ee_we) begin
         ee_mem[ee_wa] <= ee_wd;
      end
   end

   // Page buffer write port; it keeps its words between pages.
   always_ff @(posedge mclk) begin
      if (pb_we) begin
         pb_mem[pb_wa] <= pb_wd;
      end
   end

   // Status outputs, all from flip-flops.
   assign prog_mode = cur_ff.prog_en;
   assign nvm_busy  = ~cur_ff.st[0];
   assign cpu_run   = rel;
endmodule // smp_core
`default_nettype wire

/* test/smp_core_properties.sv */
// Checker for the serial programming port, sees only top ports.
// Assumes the short write delays of the bench and a 100 MHz mclk.
`timescale 1ns/1ns
`default_nettype none
module smp_props (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic sck,
   input wire logic mosi,
   input wire logic rst_pin_n,
   input wire logic miso,
   input wire logic prog_mode,
   input wire logic nvm_busy,
   input wire logic cpu_run
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   logic [12:0] bcnt_ff;  // Length of the current busy run.
   // Counts busy cycles so a hung write shows up.
   always_ff @(posedge mclk or negedge resetn)
      if (!resetn) bcnt_ff <= 13'h0000;
      else bcnt_ff <= nvm_busy ? bcnt_ff + 13'h0001 : 13'h0000;
   // A self-timed write lasts at least eight cycles.
   sequence busy_run;
      nvm_busy [*8];
   endsequence
   miso_edge_a: assert property ($changed(miso) |-> !sck)
      else $error("miso moved while sck high");
   pin_low_a: assert property (!rst_pin_n [*3] |-> !cpu_run)
      else $error("cpu runs during session");
   pin_high_a: assert property (rst_pin_n [*3] |-> cpu_run)
      else $error("cpu held after pin release");
   leave_prog_a: assert property (cpu_run [*4] |-> !prog_mode)
      else $error("still enabled after release");
   enable_pin_a: assert property ($rose(prog_mode) |-> !cpu_run)
      else $error("enabled outside session");
   busy_enabled_a: assert property ($rose(nvm_busy) |-> prog_mode)
      else $error("write started while disabled");
   busy_min_a: assert property ($rose(nvm_busy) |-> busy_run)
      else $error("write ended too soon");
   busy_bound_a: assert property (bcnt_ff < 13'h1388)
      else $error("write never ended");
endmodule // smp_props
`default_nettype wire

/* test/smp_prog.sv */
// Behavioural programmer driving the serial lines from the mclk falling edge.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ns
`default_nettype none
module smp_prog (
   input  wire logic mclk,
   input  wire logic miso,
   output logic      sck,
   output logic      mosi,
   output logic      rst_pin_n
);
   // Power up with clock and reset pin low.
   initial begin
      sck = 1'b0;
      mosi = 1'b0;
      rst_pin_n = 1'b0;
   end
   // Sets the reset pin level.
   task automatic pin(input logic v);
      @(negedge mclk);
      rst_pin_n = v;
   endtask
   // Shifts one whole frame, msb first, seven mclk per phase.
   task automatic xfer(input logic [31:0] i, output logic [31:0] o);
      for (int k = 31; k >= 0; k--) begin
         mosi = i[k];
         repeat (7) @(negedge mclk);
         o[k] = miso;
         sck = 1'b1;
         repeat (7) @(negedge mclk);
         sck = 1'b0;
      end
   endtask
   // Enables programming, retrying once with a pin pulse on a bad echo.
   task automatic enable(output logic [31:0] o);
      repeat (20) @(negedge mclk);
      xfer(32'hAC530000, o);
      if (o[15:8] !== 8'h53) begin
         pin(1'b1);
         repeat (3) @(negedge mclk);
         pin(1'b0);
         repeat (4) @(negedge mclk);
         xfer(32'hAC530000, o);
      end
   endtask
endmodule // smp_prog
`default_nettype wire

/* test/serial_memory_programming_test.sv */
// Self-checking bench for the serial programming port.
// Assumes short write delays set through the top parameters.
`timescale 1ns/1ns
`default_nettype none
module serial_memory_programming_test;
   logic        mclk, resetn, sck, mosi, rst_pin_n, miso, prog_mode, nvm_busy, cpu_run;
   int          fails, compares, seed;
   logic [31:0] o;
   logic [11:0] a;
   logic [7:0]  d, h;
   smp_core #(.FLASH_WAIT_CYC(600), .EEPROM_WAIT_CYC(600), .ERASE_WAIT_CYC(30)) dut (
      .mclk, .resetn, .sck, .mosi, .rst_pin_n, .miso, .prog_mode, .nvm_busy, .cpu_run);
   smp_prog prog (.mclk, .miso, .sck, .mosi, .rst_pin_n);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Flash read and page load frames.
   function automatic logic [31:0] fl_rd(logic [11:0] w, logic hb);
      return {4'h2, hb, 3'h0, 4'h0, w, 8'h00};
   endfunction
   function automatic logic [31:0] fl_ld(logic [11:0] w, logic hb, logic [7:0] v);
      return {4'h4, hb, 3'h0, 8'h00, 3'h0, w[4:0], v};
   endfunction
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      compares++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rd(input logic [31:0] i, input logic [7:0] e, input string n);
      prog.xfer(i, o);
      chk(n, e, o[7:0]);
   endtask
   // Polls busy; only reads and this wait run while a write is active.
   task automatic waitb;
      for (int n = 0; n < 9000 && nvm_busy !== 1'b0; n++) @(negedge mclk);
      chk("idle", 8'h00, {7'h00, nvm_busy});
   endtask
   task automatic wrap_up;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      #600000;
      fails++;
      wrap_up;
   end
   initial begin
      seed = 57643;
      resetn = 1'b0;
      repeat (2) @(negedge mclk);
      resetn = 1'b1;
      repeat (5) @(negedge mclk);
      prog.xfer(32'hC0001000, o);
      chk("busy", 8'h00, {7'h00, nvm_busy});
      prog.enable(o);
      chk("echo", 8'h53, o[15:8]);
      chk("mode", 8'h01, {7'h00, prog_mode});
      rd(32'h30000000, 8'h5A, "sig");
      prog.xfer(32'hAC800000, o);
      waitb;
      for (int k = 0; k < 4; k++) begin
         a = 12'($random(seed));
         rd(fl_rd(a, 1'b0), 8'hFF, "flash");
         rd({8'hA0, 7'h00, a[8:0], 8'h00}, 8'hFF, "eeprom");
      end
      $display("done erase");
      for (int j = 0; j < 2; j++) begin
         d = 8'($random(seed));
         prog.xfer({8'hC0, 7'h00, a[8:0], d}, o);
         rd({8'hA0, 7'h00, a[8:0], 8'h00}, 8'hFF, "ee busy");
         waitb;
         rd({8'hA0, 7'h00, a[8:0], 8'h00}, d, "ee data");
      end
      $display("done eeprom");
      d = 8'($random(seed));
      h = 8'($random(seed));
      prog.xfer(fl_ld(a, 1'b0, d), o);
      prog.xfer(fl_ld(a, 1'b1, h), o);
      prog.xfer({8'h4C, 4'h0, a[11:5], 13'h0000}, o);
      rd(fl_rd(a, 1'b0), 8'hFF, "page busy");
      waitb;
      rd(fl_rd(a, 1'b0), d, "flash lo");
      rd(fl_rd(a, 1'b1), h, "flash hi");
      $display("done page");
      prog.xfer({8'hAC, 8'hA0, 8'h00, h}, o);
      waitb;
      rd(32'h50000000, h, "fuse lo");
      prog.xfer({8'hAC, 8'hA8, 8'h00, d}, o);
      waitb;
      rd(32'h58080000, d, "fuse hi");
      prog.xfer({8'hAC, 8'hE0, 8'h00, h}, o);
      waitb;
      rd(32'h58000000, h | 8'hC0, "lock");
      rd(32'h38000000, 8'h80, "cal");
      $display("done fuse");
      prog.pin(1'b1);
      repeat (6) @(negedge mclk);
      chk("run", 8'h01, {7'h00, cpu_run});
      chk("mode", 8'h00, {7'h00, prog_mode});
      wrap_up;
   end
endmodule // serial_memory_programming_test
bind smp_core smp_props chk_i (.mclk, .resetn, .sck, .mosi, .rst_pin_n, .miso,
   .prog_mode, .nvm_busy, .cpu_run);
`default_nettype wire
